// *** can_xcvr_mode_ctrl.sv ***
// What this block does
// R1: reset enters off mode; off allowed always and ignores bus wake activity
// R2: normal mode accepted only in device normal or stop; half-supply bias
// R3: normal mode drives bus from transmit input; receive follows the bus
// R4: controller keeps transmit recessive until enable delay has elapsed
// R5: dominant present during enable delay blocked; next dominant after recessive sent
// R6: receive-only in device normal or stop; driver off, receive follows bus
// R7: wake-capable selectable in stop, sleep, restart, normal; forced on fail-safe
// R8: bus wake in wake-capable drives receive low until mode changes
// R9: wake needs dominant, recessive, dominant, each between min and max time
// R10: mode field keeps wake code after wake; detection stays disarmed
// R11: rearm by mode toggle, or entering stop, sleep or fail-safe
// R12: wake in stop or normal: interrupt low, wake status, receive low
// R13: stop wake with watchdog off and enable bit set enables watchdog
// R14: wake in sleep requests restart, receive low, no interrupt
// R15: termination per mode: half, half or 2.5 V, ground or 2.5 V, float
// R16: ground termination only after silence time on entering wake-capable
// R17: transmit dominant beyond time-out forces recessive, sets fault, mode kept
// R18: transmitter re-enables once transmit input no longer dominant
// R19: bus dominant beyond clamp time in normal or receive-only sets fault
// R20: clamp filter time always longer than transmit time-out
// R21: supply undervoltage sets flag, disables transmitter; recovers automatically
// R22: undervoltage monitored only while upper mode bit is one
// R23: two-bit mode field, four codes; fault sticky until software clears
`timescale 1ns/100ps
module can_xcvr_mode_ctrl #(
	parameter can_xcvr_pkg::cnt_t WAKE_MAX_CYC = can_xcvr_pkg::WAKE_MAX_CYC,
	parameter can_xcvr_pkg::cnt_t SILENCE_CYC = can_xcvr_pkg::SILENCE_CYC,
	parameter can_xcvr_pkg::cnt_t TX_TO_CYC = can_xcvr_pkg::TX_TO_CYC,
	parameter can_xcvr_pkg::cnt_t CLAMP_CYC = can_xcvr_pkg::CLAMP_CYC
) (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic SRST_I,
	// register bus
	input wire can_xcvr_pkg::apb_req_s APB_REQ_I,
	output can_xcvr_pkg::apb_rsp_s APB_RSP_O,
	// protocol controller side
	input wire logic TX_DATA_IN_I,
	output logic RX_DATA_OUT_O,
	output logic INTERRUPT_OUT_N_O,
	// bus side
	input wire logic BUS_DOMINANT_I,
	output logic TX_DRIVE_DOMINANT_O,
	output logic DRIVER_ENABLE_O,
	output can_xcvr_pkg::term_t TERMINATION_O,
	// device supervision
	input wire can_xcvr_pkg::dev_mode_t DEVICE_MODE_I,
	input wire logic SUPPLY_UNDERVOLTAGE_I,
	input wire logic WATCHDOG_DISABLED_I,
	output logic RESTART_REQUEST_O,
	output logic WATCHDOG_ENABLE_REQUEST_O
);
	import can_xcvr_pkg::*;

	// clamp filter kept above the transmit time-out
	localparam cnt_t CLAMP_EFF = (CLAMP_CYC > TX_TO_CYC) ?
		CLAMP_CYC : cnt_t'(TX_TO_CYC + cnt_t'(1)); // see R20

	state_s s;
	state_s next_s;

	// ==========================================================
	// helpers
	function automatic cnt_t sat_inc(input cnt_t c);
		sat_inc = (c == {CNT_W{1'b1}}) ? c : cnt_t'(c + cnt_t'(1));
	endfunction

	function automatic logic mode_legal(input xcvr_mode_t m,
			input dev_mode_t d);
		logic ns;
		ns = (d == DEV_NORMAL) || (d == DEV_STOP);
		case (m)
			MODE_OFF: mode_legal = 1'b1; // see R1
			MODE_NORMAL: mode_legal = ns; // see R2
			MODE_RXONLY: mode_legal = ns; // see R6
			MODE_WAKE: mode_legal = ns || (d == DEV_SLEEP) ||
				(d == DEV_RESTART); // see R7
			default: mode_legal = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic acc;
		logic wr;
		logic ctrl_wr;
		logic [31:0] clr;
		logic dev_enter;
		logic fault_set;
		logic uv_set;
		logic wake_hit;
		logic int_set;
		logic tx_dom_in;
		logic uv_act;
		acc = 1'b0;
		wr = 1'b0;
		ctrl_wr = 1'b0;
		clr = 32'h0000_0000;
		dev_enter = 1'b0;
		fault_set = 1'b0;
		uv_set = 1'b0;
		wake_hit = 1'b0;
		int_set = 1'b0;
		tx_dom_in = 1'b0;
		uv_act = 1'b0;
		next_s = s;
		next_s.restart_req = 1'b0;
		next_s.wd_req = 1'b0;
		next_s.rsp = '0;

		acc = APB_REQ_I.psel && APB_REQ_I.penable && s.rsp.pready;
		wr = acc && APB_REQ_I.pwrite;
		ctrl_wr = wr && (APB_REQ_I.paddr == CTRL_OFS);
		if (wr && (APB_REQ_I.paddr == STATUS_OFS)) begin
			clr = APB_REQ_I.pwdata;
		end
		dev_enter = (DEVICE_MODE_I != s.prev_dev);
		next_s.prev_dev = DEVICE_MODE_I;
		tx_dom_in = !TX_DATA_IN_I;

		// enabling delay, then wait for recessive before passing dominant
		if (s.mode == MODE_NORMAL) begin
			if (!s.en_done) begin
				if (s.en_cnt >= cnt_t'(EN_CYC - cnt_t'(1))) begin
					next_s.en_done = 1'b1;
				end else begin
					next_s.en_cnt = sat_inc(s.en_cnt);
				end
			end else if (!tx_dom_in) begin
				next_s.tx_armed = 1'b1; // see R4, R5
			end
		end

		// transmit dominant time-out
		if ((s.mode == MODE_NORMAL) && tx_dom_in) begin
			next_s.to_cnt = sat_inc(s.to_cnt);
			if (s.to_cnt >= TX_TO_CYC) begin
				next_s.tx_to = 1'b1; // see R17
				fault_set = 1'b1; // see R17
			end
		end else begin
			next_s.to_cnt = '0;
			next_s.tx_to = 1'b0; // see R18
		end

		// bus dominant clamp
		if (s.mode[1] && BUS_DOMINANT_I) begin
			next_s.cl_cnt = sat_inc(s.cl_cnt);
			if (s.cl_cnt >= CLAMP_EFF) begin
				fault_set = 1'b1; // see R19
			end
		end else begin
			next_s.cl_cnt = '0;
		end

		// undervoltage monitored only with upper mode bit set
		uv_act = s.mode[1] && SUPPLY_UNDERVOLTAGE_I; // see R22
		uv_set = uv_act; // see R21

		// wake pattern: dominant, recessive, dominant
		if ((s.mode == MODE_WAKE) && s.armed) begin
			next_s.ph_cnt = sat_inc(s.ph_cnt);
			case (s.wk)
				WK_IDLE: begin
					next_s.ph_cnt = '0;
					if (BUS_DOMINANT_I) begin
						next_s.wk = WK_DOM1;
					end
				end
				WK_DOM1: begin
					if (!BUS_DOMINANT_I) begin
						next_s.ph_cnt = '0;
						next_s.wk = (s.ph_cnt >= WAKE_MIN_CYC) ?
							WK_REC : WK_IDLE; // see R9
					end else if (s.ph_cnt >= WAKE_MAX_CYC) begin
						next_s.wk = WK_IDLE; // see R9
					end
				end
				WK_REC: begin
					if (BUS_DOMINANT_I) begin
						next_s.ph_cnt = '0;
						next_s.wk = (s.ph_cnt >= WAKE_MIN_CYC) ?
							WK_DOM2 : WK_DOM1; // see R9
					end else if (s.ph_cnt >= WAKE_MAX_CYC) begin
						next_s.wk = WK_IDLE; // see R9
					end
				end
				WK_DOM2: begin
					if (!BUS_DOMINANT_I) begin
						next_s.ph_cnt = '0;
						if (s.ph_cnt >= WAKE_MIN_CYC) begin
							wake_hit = 1'b1; // see R9
							next_s.wk = WK_IDLE;
						end else begin
							next_s.wk = WK_REC;
						end
					end else if (s.ph_cnt >= WAKE_MAX_CYC) begin
						next_s.wk = WK_IDLE; // see R9
					end
				end
				default: next_s.wk = WK_IDLE;
			endcase
		end else begin
			next_s.wk = WK_IDLE;
			next_s.ph_cnt = '0;
		end

		// wake actions per device mode; mode field untouched
		if (wake_hit) begin
			next_s.armed = 1'b0; // see R10
			next_s.woken = 1'b1; // see R8
			if ((DEVICE_MODE_I == DEV_STOP) ||
					(DEVICE_MODE_I == DEV_NORMAL)) begin
				int_set = 1'b1; // see R12
			end
			if ((DEVICE_MODE_I == DEV_STOP) && s.wd_bit &&
					WATCHDOG_DISABLED_I) begin
				next_s.wd_req = 1'b1; // see R13
			end
			if ((DEVICE_MODE_I == DEV_SLEEP) ||
					(DEVICE_MODE_I == DEV_FAILSAFE)) begin
				next_s.restart_req = 1'b1; // see R14
			end
		end

		// silence time before ground termination
		if ((s.mode == MODE_WAKE) && !s.sil_done) begin
			if (s.sil_cnt >= cnt_t'(SILENCE_CYC - cnt_t'(1))) begin
				next_s.sil_done = 1'b1; // see R16
			end else begin
				next_s.sil_cnt = sat_inc(s.sil_cnt);
			end
		end

		// automatic rearm on device mode entry
		if (dev_enter && ((DEVICE_MODE_I == DEV_STOP) ||
				(DEVICE_MODE_I == DEV_SLEEP) ||
				(DEVICE_MODE_I == DEV_FAILSAFE))) begin
			next_s.armed = 1'b1; // see R11
		end

		// sticky flags, hardware set wins over clear
		next_s.fault = (s.fault && !clr[ST_FAULT_BIT]) ||
			fault_set; // see R23
		next_s.uv_flag = (s.uv_flag && !clr[ST_UV_BIT]) || uv_set;
		next_s.wake_stat = (s.wake_stat && !clr[ST_WAKE_BIT]) ||
			wake_hit; // see R12, R14
		next_s.int_low = (s.int_low && !clr[ST_WAKE_BIT]) || int_set;

		// software mode selection; fail-safe entry forces wake-capable
		if (ctrl_wr) begin
			next_s.wd_bit = APB_REQ_I.pwdata[CTRL_WD_BIT];
			if (mode_legal(APB_REQ_I.pwdata[CTRL_MODE_LSB +: 2],
					DEVICE_MODE_I)) begin
				next_s.mode = APB_REQ_I.pwdata[CTRL_MODE_LSB +: 2]; // see R23
			end
		end
		if (dev_enter && (DEVICE_MODE_I == DEV_FAILSAFE)) begin
			next_s.mode = MODE_WAKE; // see R7
		end

		// any mode change restarts sequences; toggle rearms wake
		if (next_s.mode != s.mode) begin
			next_s.woken = 1'b0; // see R8
			next_s.armed = 1'b1; // see R11
			next_s.en_cnt = '0;
			next_s.en_done = 1'b0;
			next_s.tx_armed = 1'b0;
			next_s.tx_to = 1'b0;
			next_s.to_cnt = '0;
			next_s.cl_cnt = '0;
			next_s.sil_cnt = '0;
			next_s.sil_done = 1'b0;
			next_s.wk = WK_IDLE;
			next_s.ph_cnt = '0;
		end

		// pin outputs
		next_s.tx_dom = (next_s.mode == MODE_NORMAL) && next_s.en_done &&
			next_s.tx_armed && !next_s.tx_to && !uv_act &&
			tx_dom_in; // see R3, R5, R17, R21
		next_s.drv_en = (next_s.mode == MODE_NORMAL) && next_s.en_done &&
			!next_s.tx_to && !uv_act; // see R6, R18, R21
		case (next_s.mode)
			MODE_NORMAL: begin
				next_s.rx = !BUS_DOMINANT_I; // see R3
				next_s.term = TERM_HALF; // see R2, R15
			end
			MODE_RXONLY: begin
				next_s.rx = !BUS_DOMINANT_I; // see R6
				next_s.term = uv_act ? TERM_2V5 : TERM_HALF; // see R15
			end
			MODE_WAKE: begin
				next_s.rx = !next_s.woken; // see R8
				next_s.term = next_s.woken ? TERM_2V5 :
					(next_s.sil_done ? TERM_GND : TERM_FLOAT); // see R15
			end
			default: begin
				next_s.rx = 1'b1; // see R1
				next_s.term = TERM_FLOAT; // see R15
			end
		endcase
		next_s.int_n = !next_s.int_low; // see R12

		// register bus answer, one wait state
		if (APB_REQ_I.psel && APB_REQ_I.penable && !s.rsp.pready) begin
			next_s.rsp.pready = 1'b1;
			case (APB_REQ_I.paddr)
				CTRL_OFS: begin
					next_s.rsp.prdata[CTRL_MODE_LSB +: 2] = s.mode; // see R10
					next_s.rsp.prdata[CTRL_WD_BIT] = s.wd_bit;
				end
				STATUS_OFS: begin
					next_s.rsp.prdata[ST_FAULT_BIT] = s.fault;
					next_s.rsp.prdata[ST_UV_BIT] = s.uv_flag;
					next_s.rsp.prdata[ST_WAKE_BIT] = s.wake_stat;
					next_s.rsp.prdata[ST_TXTO_BIT] = s.tx_to;
					next_s.rsp.prdata[ST_EN_BIT] = s.en_done;
					next_s.rsp.prdata[ST_ARMED_BIT] = s.armed;
				end
				default: next_s.rsp.pslverr = 1'b1;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			s <= '0;
			s.mode <= MODE_RST; // see R1
			s.armed <= 1'b1;
			s.wk <= WK_IDLE;
			s.prev_dev <= DEV_NORMAL;
			s.rx <= 1'b1;
			s.int_n <= 1'b1;
			s.term <= TERM_FLOAT;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign APB_RSP_O = s.rsp;
	assign RX_DATA_OUT_O = s.rx;
	assign INTERRUPT_OUT_N_O = s.int_n;
	assign TX_DRIVE_DOMINANT_O = s.tx_dom;
	assign DRIVER_ENABLE_O = s.drv_en;
	assign TERMINATION_O = s.term;
	assign RESTART_REQUEST_O = s.restart_req;
	assign WATCHDOG_ENABLE_REQUEST_O = s.wd_req;

endmodule

// *** can_xcvr_pkg.sv ***
package can_xcvr_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_NS = 25;
	localparam int CNT_W = 20;
	typedef logic [CNT_W-1:0] cnt_t;

	// least times round up, longest times round down
	localparam int EN_TIME_NS = 10000;
	localparam int WAKE_MIN_NS = 500;
	localparam int WAKE_MAX_NS = 1800000;
	localparam int SILENCE_NS = 1000000;
	localparam int TX_TO_NS = 2700000;
	localparam int CLAMP_NS = 4500000;
	localparam cnt_t EN_CYC = cnt_t'((EN_TIME_NS + CLK_NS - 1) / CLK_NS);
	localparam cnt_t WAKE_MIN_CYC = cnt_t'((WAKE_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam cnt_t WAKE_MAX_CYC = cnt_t'(WAKE_MAX_NS / CLK_NS);
	localparam cnt_t SILENCE_CYC = cnt_t'((SILENCE_NS + CLK_NS - 1) / CLK_NS);
	localparam cnt_t TX_TO_CYC = cnt_t'((TX_TO_NS + CLK_NS - 1) / CLK_NS);
	localparam cnt_t CLAMP_CYC = cnt_t'((CLAMP_NS + CLK_NS - 1) / CLK_NS);

	// ==========================================================
	// register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_WD_BIT = 2;
	localparam int ST_FAULT_BIT = 0;
	localparam int ST_UV_BIT = 1;
	localparam int ST_WAKE_BIT = 2;
	localparam int ST_TXTO_BIT = 3;
	localparam int ST_EN_BIT = 4;
	localparam int ST_ARMED_BIT = 5;

	// ==========================================================
	// codes
	typedef logic [1:0] xcvr_mode_t;
	localparam xcvr_mode_t MODE_OFF = 2'h0;
	localparam xcvr_mode_t MODE_WAKE = 2'h1;
	localparam xcvr_mode_t MODE_RXONLY = 2'h2;
	localparam xcvr_mode_t MODE_NORMAL = 2'h3;
	localparam xcvr_mode_t MODE_RST = MODE_OFF;

	typedef logic [2:0] dev_mode_t;
	localparam dev_mode_t DEV_NORMAL = 3'h0;
	localparam dev_mode_t DEV_STOP = 3'h1;
	localparam dev_mode_t DEV_SLEEP = 3'h2;
	localparam dev_mode_t DEV_RESTART = 3'h3;
	localparam dev_mode_t DEV_FAILSAFE = 3'h4;

	typedef logic [1:0] term_t;
	localparam term_t TERM_FLOAT = 2'h0;
	localparam term_t TERM_HALF = 2'h1;
	localparam term_t TERM_2V5 = 2'h2;
	localparam term_t TERM_GND = 2'h3;

	typedef enum logic [1:0] {WK_IDLE, WK_DOM1, WK_REC, WK_DOM2} wake_st_e;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_s;

	typedef struct packed {
		xcvr_mode_t mode;
		logic wd_bit;
		logic fault;
		logic uv_flag;
		logic wake_stat;
		logic int_low;
		cnt_t en_cnt;
		logic en_done;
		logic tx_armed;
		logic tx_to;
		cnt_t to_cnt;
		cnt_t cl_cnt;
		wake_st_e wk;
		cnt_t ph_cnt;
		logic armed;
		logic woken;
		cnt_t sil_cnt;
		logic sil_done;
		dev_mode_t prev_dev;
		logic tx_dom;
		logic drv_en;
		logic rx;
		logic int_n;
		term_t term;
		logic restart_req;
		logic wd_req;
		apb_rsp_s rsp;
	} state_s;

endpackage

// *** can_bus_model.sv ***
`timescale 1ns/100ps
module can_bus_model (
	// from the block under test
	input wire logic drv_en_i,
	input wire logic drv_dom_i,
	// other nodes on the bus
	input wire logic ext_dom_i,
	// digitised bus level
	output logic bus_dom_o
);
	// recessive unless some node drives dominant
	assign bus_dom_o = ext_dom_i | (drv_en_i & drv_dom_i);
endmodule

// *** can_xcvr_mode_ctrl_props.sv ***
`timescale 1ns/100ps
module can_xcvr_mode_ctrl_props
	import can_xcvr_pkg::*;
#(
	parameter can_xcvr_pkg::cnt_t TX_TO_CYC = can_xcvr_pkg::TX_TO_CYC
) (
	// clock, reset and inputs
	input wire logic CLK_SYS_I,
	input wire logic SRST_I,
	input wire can_xcvr_pkg::apb_req_s APB_REQ_I,
	input wire logic TX_DATA_IN_I,
	input wire can_xcvr_pkg::dev_mode_t DEVICE_MODE_I,
	input wire logic SUPPLY_UNDERVOLTAGE_I,
	input wire logic WATCHDOG_DISABLED_I,
	// block outputs
	input wire can_xcvr_pkg::apb_rsp_s APB_RSP_O,
	input wire logic RX_DATA_OUT_O,
	input wire logic INTERRUPT_OUT_N_O,
	input wire logic TX_DRIVE_DOMINANT_O,
	input wire logic DRIVER_ENABLE_O,
	input wire can_xcvr_pkg::term_t TERMINATION_O,
	input wire logic RESTART_REQUEST_O,
	input wire logic WATCHDOG_ENABLE_REQUEST_O
);
	// ==========
	// dominant transmit run length
	int lo_cnt;
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I || TX_DATA_IN_I)
			lo_cnt <= 0;
		else if (lo_cnt < 1000000)
			lo_cnt <= lo_cnt + 1;
	end

	// ==========
	// properties
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SRST_I);
	sequence s_access;
		APB_REQ_I.psel && APB_REQ_I.penable && !APB_RSP_O.pready;
	endsequence
	sequence s_int_fall;
		$fell(INTERRUPT_OUT_N_O);
	endsequence

	a_rst_off: assert property ($fell(SRST_I) |-> RX_DATA_OUT_O &&
		INTERRUPT_OUT_N_O && !DRIVER_ENABLE_O && TERMINATION_O == TERM_FLOAT)
		else $error("outputs not off after reset");
	a_apb_answer: assert property (s_access |=> APB_RSP_O.pready)
		else $error("no ready after access cycle");
	a_drv_term: assert property (DRIVER_ENABLE_O |->
		TERMINATION_O == TERM_HALF) else $error("driver on without half bias");
	a_tx_cause: assert property (TX_DRIVE_DOMINANT_O |->
		!$past(TX_DATA_IN_I)) else $error("dominant sent without cause");
	a_tx_timeout: assert property (lo_cnt > int'(TX_TO_CYC) + 3 |->
		!TX_DRIVE_DOMINANT_O) else $error("dominant beyond time-out");
	a_uv_drv: assert property (SUPPLY_UNDERVOLTAGE_I |=>
		!DRIVER_ENABLE_O) else $error("driver on in undervoltage");
	a_sleep_noint: assert property (RESTART_REQUEST_O |->
		!$fell(INTERRUPT_OUT_N_O) ##1 !RESTART_REQUEST_O)
		else $error("restart wake misbehaved");
	a_wd_req: assert property (WATCHDOG_ENABLE_REQUEST_O |->
		$past(WATCHDOG_DISABLED_I) && $past(DEVICE_MODE_I) == DEV_STOP)
		else $error("watchdog request without cause");
	a_int_rx: assert property (s_int_fall |-> !RX_DATA_OUT_O)
		else $error("interrupt without receive low");
	a_gnd_silence: assert property (TERMINATION_O == TERM_GND &&
		$past(TERMINATION_O) != TERM_GND |-> $past(TERMINATION_O) == TERM_FLOAT)
		else $error("ground termination without silence");
endmodule

bind can_xcvr_mode_ctrl can_xcvr_mode_ctrl_props #(
	.TX_TO_CYC(TX_TO_CYC)
) i_props (.*);

// *** can_xcvr_mode_ctrl_tb_top.sv ***
`timescale 1ns/100ps
module can_xcvr_mode_ctrl_tb_top;
	import can_xcvr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tx = 1'b1;
	logic uv = 1'b0;
	logic wdd = 1'b0;
	logic ext = 1'b0;
	logic seen_r = 1'b0;
	logic seen_w = 1'b0;
	logic er;
	logic rxo, interrupt_out_n, txd, den, rr, wr, bus;
	logic [31:0] rd;
	apb_req_s req = '0;
	apb_rsp_s rsp;
	dev_mode_t dm = DEV_NORMAL;
	term_t term;
	int miscompares = 0;
	int n_compared = 0;

	always #12.5 clk = ~clk;

	can_xcvr_mode_ctrl #(
		.WAKE_MAX_CYC(20'h0_0064),
		.SILENCE_CYC(20'h0_0032),
		.TX_TO_CYC(20'h0_00c8),
		.CLAMP_CYC(20'h0_012c)
	) i_dut (
		.CLK_SYS_I(clk),
		.SRST_I(rst),
		.APB_REQ_I(req),
		.APB_RSP_O(rsp),
		.TX_DATA_IN_I(tx),
		.RX_DATA_OUT_O(rxo),
		.INTERRUPT_OUT_N_O(interrupt_out_n),
		.BUS_DOMINANT_I(bus),
		.TX_DRIVE_DOMINANT_O(txd),
		.DRIVER_ENABLE_O(den),
		.TERMINATION_O(term),
		.DEVICE_MODE_I(dm),
		.SUPPLY_UNDERVOLTAGE_I(uv),
		.WATCHDOG_DISABLED_I(wdd),
		.RESTART_REQUEST_O(rr),
		.WATCHDOG_ENABLE_REQUEST_O(wr)
	);

	can_bus_model i_bus (
		.drv_en_i(den),
		.drv_dom_i(txd),
		.ext_dom_i(ext),
		.bus_dom_o(bus)
	);

	// ==========
	// helpers
	always @(posedge clk) begin
		if (rr)
			seen_r <= 1'b1;
		if (wr)
			seen_w <= 1'b1;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input string s, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n = 0;
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do
			@(posedge clk);
		while (rsp.pready !== 1'b1 && ++n < 20);
		chk("pready", 1, rsp.pready);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		@(posedge clk);
	endtask

	// dominant, recessive, dominant, then long idle
	task automatic wk(input int d1);
		ext <= 1'b1;
		cyc(d1);
		ext <= 1'b0;
		cyc(30);
		ext <= 1'b1;
		cyc(30);
		ext <= 1'b0;
		cyc(110);
	endtask

	task final_report;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		cyc(60000);
		miscompares++;
		final_report;
	end

	// ==========
	// tests
	initial begin
		cyc(5);
		rst <= 1'b0;
		cyc(1);
		chk("term", TERM_FLOAT, term);
		apb(0, CTRL_OFS, 0);
		chk("ctrl", MODE_OFF, rd);
		apb(0, 8'h08, 0);
		chk("slverr", 1, er);
		wk(30);
		chk("rx off", 1, rxo);
		$display("reset test done");
		tx <= 1'b0;
		apb(1, CTRL_OFS, MODE_NORMAL);
		cyc(EN_CYC + 20);
		chk("txd early", 0, txd);
		chk("term", TERM_HALF, term);
		tx <= 1'b1;
		cyc(3);
		apb(1, STATUS_OFS, 1 << ST_FAULT_BIT);
		tx <= 1'b0;
		cyc(3);
		chk("txd", 1, txd);
		chk("rx", 0, rxo);
		cyc(210);
		chk("txd to", 0, txd);
		apb(0, STATUS_OFS, 0);
		chk("fault", 1, rd[ST_FAULT_BIT]);
		apb(0, CTRL_OFS, 0);
		chk("ctrl", MODE_NORMAL, rd[1:0]);
		tx <= 1'b1;
		cyc(3);
		chk("den", 1, den);
		apb(1, STATUS_OFS, 1 << ST_FAULT_BIT);
		apb(0, STATUS_OFS, 0);
		chk("fault clr", 0, rd[ST_FAULT_BIT]);
		ext <= 1'b1;
		cyc(310);
		ext <= 1'b0;
		apb(0, STATUS_OFS, 0);
		chk("clamp", 1, rd[ST_FAULT_BIT]);
		uv <= 1'b1;
		cyc(3);
		chk("den uv", 0, den);
		uv <= 1'b0;
		cyc(3);
		chk("den back", 1, den);
		apb(0, STATUS_OFS, 0);
		chk("uv flag", 1, rd[ST_UV_BIT]);
		$display("normal test done");
		dm <= DEV_STOP;
		apb(1, CTRL_OFS, MODE_RXONLY);
		chk("den rxo", 0, den);
		uv <= 1'b1;
		cyc(3);
		chk("term rxo uv", TERM_2V5, term);
		uv <= 1'b0;
		cyc(3);
		chk("term rxo", TERM_HALF, term);
		ext <= 1'b1;
		cyc(3);
		chk("rx rxo", 0, rxo);
		ext <= 1'b0;
		dm <= DEV_SLEEP;
		apb(1, CTRL_OFS, MODE_NORMAL);
		apb(0, CTRL_OFS, 0);
		chk("refused", MODE_RXONLY, rd[1:0]);
		dm <= DEV_STOP;
		wdd <= 1'b1;
		apb(1, CTRL_OFS, 32'h0000_0005);
		chk("silence", TERM_FLOAT, term);
		cyc(60);
		chk("gnd", TERM_GND, term);
		wk(10);
		wk(120);
		chk("bad wake", 1, rxo);
		wk(30);
		chk("rx wake", 0, rxo);
		chk("int", 0, interrupt_out_n);
		chk("term wk", TERM_2V5, term);
		chk("wd req", 1, seen_w);
		apb(0, CTRL_OFS, 0);
		chk("ctrl wk", 32'h0000_0005, rd);
		apb(1, STATUS_OFS, 1 << ST_WAKE_BIT);
		chk("int clr", 1, interrupt_out_n);
		wk(30);
		apb(0, STATUS_OFS, 0);
		chk("disarmed", 0, rd[ST_WAKE_BIT]);
		apb(1, CTRL_OFS, MODE_OFF);
		chk("rx free", 1, rxo);
		apb(1, CTRL_OFS, MODE_WAKE);
		wk(30);
		chk("rearm", 0, interrupt_out_n);
		apb(1, STATUS_OFS, 1 << ST_WAKE_BIT);
		$display("wake test done");
		dm <= DEV_SLEEP;
		cyc(2);
		wk(30);
		chk("restart", 1, seen_r);
		chk("no int", 1, interrupt_out_n);
		apb(1, CTRL_OFS, MODE_OFF);
		dm <= DEV_FAILSAFE;
		cyc(2);
		apb(0, CTRL_OFS, 0);
		chk("failsafe", MODE_WAKE, rd[1:0]);
		$display("sleep test done");
		final_report;
	end
endmodule
